/* File: hw/event_counter_pkg.sv */
// Package for the event counter input selection block.
// Assumes an APB master with 32-bit data; one register per aligned word.
package event_counter_pkg;

    // Register byte offsets
    localparam logic [7:0] OFFS_EDGE_SELECT  = 8'h00;
    localparam logic [7:0] OFFS_CLOCK_CTRL   = 8'h04;
    localparam logic [7:0] OFFS_COUNT_STATUS = 8'h08;
    localparam logic [7:0] OFFS_CASCADE_CTRL = 8'h0c;

    // Reset values
    localparam logic [7:0] RESET_EDGE_SELECT = 8'h00;
    localparam logic [7:0] RESET_CLOCK_CTRL  = 8'h00;
    localparam logic [7:0] RESET_COUNT       = 8'h00;

    // Field positions, edge select register
    localparam int POS_HIGH_EDGE = 6;
    localparam int POS_LOW_EDGE  = 4;
    localparam int POS_IRQ_EDGE  = 2;
    localparam int POS_PWM_EN    = 1;

    // Field positions, clock control register
    localparam int POS_HIGH_CLK = 6;
    localparam int POS_LOW_CLK  = 4;
    localparam int POS_PWM_CLK  = 1;

    // Edge select codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Count source codes
    localparam logic [1:0] SRC_PIN  = 2'h0;
    localparam logic [1:0] SRC_DIV2 = 2'h1;
    localparam logic [1:0] SRC_DIV4 = 2'h2;
    localparam logic [1:0] SRC_DIV8 = 2'h3;

    // Divider exponents (divide by 2**n)
    localparam logic [2:0] LOG_DIV2  = 3'h1;
    localparam logic [2:0] LOG_DIV4  = 3'h2;
    localparam logic [2:0] LOG_DIV8  = 3'h3;
    localparam logic [2:0] LOG_DIV16 = 3'h4;
    localparam logic [2:0] LOG_DIV32 = 3'h5;
    localparam logic [2:0] LOG_DIV64 = 3'h6;

    localparam int PRESCALE_WIDTH = 6;
    localparam logic [PRESCALE_WIDTH-1:0] RESET_PRESCALE = 6'h00;

endpackage : event_counter_pkg

/* File: hw/event_counter_input_select.sv */
// Edge sensing, count source selection and PWM clock selection for the event counter.
// Assumes pins synchronous to sys_clk and an APB master with zero-wait-tolerant timing.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Overview of operation
// - Bits 7:6 pick high pin sensed edge
// - Bits 5:4 pick low pin sensed edge
// - Bits 3:2 pick irq pin sensed edge
// - Bit 1 runs PWM, deselects irq pin
// - High source: pin, clock/2, clock/4
// - Low source: pin, /2, /4, /8
// - PWM clock divides by 4 to 64
// - High: low overflow or clock/8 too
module event_counter_input_select
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        high_event_pin,
    input  wire logic        low_event_pin,
    input  wire logic        event_irq_enable_pin,
    output logic             high_count_tick,
    output logic             low_count_tick,
    output logic             low_overflow,
    output logic             irq_event,
    output logic             pwm_clk_tick,
    output logic             counter_pwm_enable,
    output logic [7:0]       high_event_count,
    output logic [7:0]       low_event_count
);

    logic [7:0]                                    input_edge_select;
    logic [7:0]                                    counter_clock_control;
    logic                                          cascade_enable;
    logic [7:0]                                    next_input_edge_select;
    logic [7:0]                                    next_counter_clock_control;
    logic                                          next_cascade_enable;
    logic [31:0]                                   next_prdata;
    logic                                          next_pslverr;
    logic [event_counter_pkg::PRESCALE_WIDTH-1:0]  prescale;
    logic [event_counter_pkg::PRESCALE_WIDTH-1:0]  next_prescale;
    logic                                          high_pin_prev;
    logic                                          low_pin_prev;
    logic                                          irq_pin_prev;
    logic [7:0]                                    next_high_event_count;
    logic [7:0]                                    next_low_event_count;
    logic                                          next_high_tick;
    logic                                          next_low_tick;
    logic                                          next_low_overflow;
    logic                                          next_irq_event;
    logic                                          next_pwm_tick;
    logic                                          wr_strobe;
    logic                                          rd_setup;
    logic [1:0]                                    high_edge;
    logic [1:0]                                    low_edge;
    logic [1:0]                                    irq_edge;
    logic [1:0]                                    high_src;
    logic [1:0]                                    low_src;
    logic [2:0]                                    pwm_sel;
    logic [2:0]                                    pwm_log;

    // True when the pin moved in the direction the code asks for; 11 senses nothing
    function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            event_counter_pkg::EDGE_FALL: hit = prev & ~cur;
            event_counter_pkg::EDGE_RISE: hit = ~prev & cur;
            event_counter_pkg::EDGE_BOTH: hit = prev ^ cur;
            default:                      hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // One cycle in every 2**n of the free prescaler
    function automatic logic div_tick(input logic [event_counter_pkg::PRESCALE_WIDTH-1:0] pre,
                                      input logic [2:0] n);
        logic [event_counter_pkg::PRESCALE_WIDTH-1:0] mask;
        mask = ~({event_counter_pkg::PRESCALE_WIDTH{1'b1}} << n);
        return (pre & mask) == mask;
    endfunction : div_tick

    // Field decode
    assign high_edge          = input_edge_select[event_counter_pkg::POS_HIGH_EDGE +: 2];
    assign low_edge           = input_edge_select[event_counter_pkg::POS_LOW_EDGE +: 2];
    assign irq_edge           = input_edge_select[event_counter_pkg::POS_IRQ_EDGE +: 2];
    assign counter_pwm_enable = input_edge_select[event_counter_pkg::POS_PWM_EN];
    assign high_src           = counter_clock_control[event_counter_pkg::POS_HIGH_CLK +: 2];
    assign low_src            = counter_clock_control[event_counter_pkg::POS_LOW_CLK +: 2];
    assign pwm_sel            = counter_clock_control[event_counter_pkg::POS_PWM_CLK +: 3];

    // APB strobes; every access completes in its first access cycle
    assign wr_strobe = psel & penable & pwrite;
    assign rd_setup  = psel & ~penable;
    assign pready    = psel & penable;

    // Register writes in the access cycle, read data capture in the setup cycle
    always_comb
    begin
        next_input_edge_select     = input_edge_select;
        next_counter_clock_control = counter_clock_control;
        next_cascade_enable        = cascade_enable;
        next_prdata                = prdata;
        next_pslverr               = pslverr;
        if (wr_strobe && !pslverr)
        begin
            unique case (paddr)
                event_counter_pkg::OFFS_EDGE_SELECT:  next_input_edge_select = pwdata[7:0];
                event_counter_pkg::OFFS_CLOCK_CTRL:   next_counter_clock_control = pwdata[7:0];
                event_counter_pkg::OFFS_CASCADE_CTRL: next_cascade_enable = pwdata[0];
                default:                              next_cascade_enable = cascade_enable;
            endcase
        end
        if (rd_setup)
        begin
            next_pslverr = 1'b0;
            unique case (paddr)
                event_counter_pkg::OFFS_EDGE_SELECT:  next_prdata = {24'h000000, input_edge_select};
                event_counter_pkg::OFFS_CLOCK_CTRL:   next_prdata = {24'h000000, counter_clock_control};
                event_counter_pkg::OFFS_COUNT_STATUS:
                    next_prdata = {16'h0000, high_event_count, low_event_count};
                event_counter_pkg::OFFS_CASCADE_CTRL: next_prdata = {31'h00000000, cascade_enable};
                default:
                begin
                    next_prdata  = 32'h00000000;
                    next_pslverr = 1'b1;
                end
            endcase
            // Writes to the read-only count word are refused
            if (pwrite && paddr == event_counter_pkg::OFFS_COUNT_STATUS)
            begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            input_edge_select     <= event_counter_pkg::RESET_EDGE_SELECT;
            counter_clock_control <= event_counter_pkg::RESET_CLOCK_CTRL;
            cascade_enable        <= 1'b0;
            prdata                <= 32'h00000000;
            pslverr               <= 1'b0;
        end
        else
        begin
            input_edge_select     <= next_input_edge_select;
            counter_clock_control <= next_counter_clock_control;
            cascade_enable        <= next_cascade_enable;
            prdata                <= next_prdata;
            pslverr               <= next_pslverr;
        end
    end

    // PWM divider select; middle bit ignored when the top bit is set
    always_comb
    begin
        pwm_log = event_counter_pkg::LOG_DIV4;
        if (pwm_sel[2])
        begin
            pwm_log = pwm_sel[0] ? event_counter_pkg::LOG_DIV64 : event_counter_pkg::LOG_DIV32;
        end
        else
        begin
            unique case (pwm_sel[1:0])
                2'h1:    pwm_log = event_counter_pkg::LOG_DIV4;
                2'h2:    pwm_log = event_counter_pkg::LOG_DIV8;
                2'h3:    pwm_log = event_counter_pkg::LOG_DIV16;
                default: pwm_log = event_counter_pkg::LOG_DIV4;
            endcase
        end
    end

    // Prescaler, edge sensing, source select and counting
    always_comb
    begin
        next_prescale     = prescale + 6'h01;
        next_low_tick     = 1'b0;
        next_high_tick    = 1'b0;
        unique case (low_src)
            event_counter_pkg::SRC_PIN:  next_low_tick = edge_hit(low_pin_prev, low_event_pin, low_edge);
            event_counter_pkg::SRC_DIV2: next_low_tick = div_tick(prescale, event_counter_pkg::LOG_DIV2);
            event_counter_pkg::SRC_DIV4: next_low_tick = div_tick(prescale, event_counter_pkg::LOG_DIV4);
            event_counter_pkg::SRC_DIV8: next_low_tick = div_tick(prescale, event_counter_pkg::LOG_DIV8);
        endcase
        next_low_overflow = next_low_tick && low_event_count == 8'hff;
        if (cascade_enable)
        begin
            next_high_tick = next_low_overflow;
        end
        else
        begin
            unique case (high_src)
                event_counter_pkg::SRC_PIN:
                    next_high_tick = edge_hit(high_pin_prev, high_event_pin, high_edge);
                event_counter_pkg::SRC_DIV2: next_high_tick = div_tick(prescale, event_counter_pkg::LOG_DIV2);
                event_counter_pkg::SRC_DIV4: next_high_tick = div_tick(prescale, event_counter_pkg::LOG_DIV4);
                event_counter_pkg::SRC_DIV8: next_high_tick = div_tick(prescale, event_counter_pkg::LOG_DIV8);
            endcase
        end
        next_low_event_count  = low_event_count + {7'h00, next_low_tick};
        next_high_event_count = high_event_count + {7'h00, next_high_tick};
        // Irq pin only sensed while the PWM is halted
        next_irq_event = ~counter_pwm_enable & edge_hit(irq_pin_prev, event_irq_enable_pin, irq_edge);
        // PWM clock only ticks while the PWM runs
        next_pwm_tick  = counter_pwm_enable & div_tick(prescale, pwm_log);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            prescale         <= event_counter_pkg::RESET_PRESCALE;
            high_pin_prev    <= 1'b0;
            low_pin_prev     <= 1'b0;
            irq_pin_prev     <= 1'b0;
            high_event_count <= event_counter_pkg::RESET_COUNT;
            low_event_count  <= event_counter_pkg::RESET_COUNT;
            high_count_tick  <= 1'b0;
            low_count_tick   <= 1'b0;
            low_overflow     <= 1'b0;
            irq_event        <= 1'b0;
            pwm_clk_tick     <= 1'b0;
        end
        else
        begin
            prescale         <= next_prescale;
            high_pin_prev    <= high_event_pin;
            low_pin_prev     <= low_event_pin;
            irq_pin_prev     <= event_irq_enable_pin;
            high_event_count <= next_high_event_count;
            low_event_count  <= next_low_event_count;
            high_count_tick  <= next_high_tick;
            low_count_tick   <= next_low_tick;
            low_overflow     <= next_low_overflow;
            irq_event        <= next_irq_event;
            pwm_clk_tick     <= next_pwm_tick;
        end
    end

endmodule : event_counter_input_select

/* File: testbench/event_counter_properties.sv */
// Checker: port-level properties of the event counter selection block.
// Assumes writes land at the APB access edge and pins are sampled on sys_clk.
`timescale 1ns/1ps
module event_counter_properties
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        low_event_pin,
    input wire logic        event_irq_enable_pin,
    input wire logic        low_count_tick,
    input wire logic        low_overflow,
    input wire logic        irq_event,
    input wire logic        pwm_clk_tick,
    input wire logic        counter_pwm_enable,
    input wire logic [7:0]  low_event_count
);
    logic [7:0] edge_reg;
    logic [7:0] clk_reg;
    logic [7:0] gap;
    logic [1:0] low_src;
    logic       wr;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    assign wr = psel && penable && pwrite;
    assign low_src = clk_reg[5:4];
    // Shadow control registers and idle cycles since the last low tick
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || low_count_tick)
            gap <= 8'h00;
        else if (gap != 8'hff)
            gap <= gap + 8'h01;
        if (!rst_n)
        begin
            edge_reg <= 8'h00;
            clk_reg  <= 8'h00;
        end
        else if (wr && paddr == 8'h00)
            edge_reg <= pwdata[7:0];
        else if (wr && paddr == 8'h04)
            clk_reg <= pwdata[7:0];
    end
    pwm_follows_a: assert property (wr && paddr == 8'h00 |=> counter_pwm_enable == $past(pwdata[1]))
        else $error("pwm enable differs from bit 1");
    irq_gated_a: assert property (irq_event |-> !$past(counter_pwm_enable))
        else $error("irq pulse while pwm runs");
    pwm_gated_a: assert property (pwm_clk_tick |-> $past(counter_pwm_enable))
        else $error("pwm tick while pwm halted");
    low_fall_a: assert property (edge_reg[5:4] == 2'h0 && low_src == 2'h0 && $fell(low_event_pin) |=> low_count_tick)
        else $error("falling low edge not counted");
    low_rise_a: assert property (edge_reg[5:4] == 2'h1 && low_src == 2'h0 && $rose(low_event_pin) |=> low_count_tick)
        else $error("rising low edge not counted");
    pin_cause_a: assert property (low_count_tick && $past(low_src) == 2'h0 |-> $past(low_event_pin) != $past(low_event_pin, 2))
        else $error("low tick without pin change");
    low_div8_a: assert property (low_count_tick && low_src == 2'h3 && $past(low_src, 9) == 2'h3 |-> gap == 8'h07)
        else $error("low tick spacing not eight");
    wrap_flag_a: assert property (low_overflow |-> low_count_tick && low_event_count == 8'h00)
        else $error("overflow without wrap");
    irq_rise_a: assert property (edge_reg[3:2] == 2'h1 && !counter_pwm_enable && $rose(event_irq_enable_pin) |=> irq_event)
        else $error("rising irq edge missed");
    ovf_on_wrap_a: assert property (low_count_tick && low_event_count == 8'h00 |-> low_overflow)
        else $error("wrap without overflow pulse");
endmodule : event_counter_properties

bind event_counter_input_select event_counter_properties chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .low_event_pin(low_event_pin),
    .event_irq_enable_pin(event_irq_enable_pin), .low_count_tick(low_count_tick), .low_overflow(low_overflow),
    .irq_event(irq_event), .pwm_clk_tick(pwm_clk_tick), .counter_pwm_enable(counter_pwm_enable),
    .low_event_count(low_event_count));

/* File: testbench/event_source_model.sv */
// Model of the external event sources on the three counter pins.
// Assumes pins are sampled on the rising edge of sys_clk.
`timescale 1ns/1ps
module event_source_model
(
    input  wire logic sys_clk,
    output logic      high_event_pin,
    output logic      low_event_pin,
    output logic      event_irq_enable_pin
);
    initial
    begin
        high_event_pin = 1'b0;
        low_event_pin = 1'b0;
        event_irq_enable_pin = 1'b0;
    end
    // Flip the masked pins once per cycle, n times in a row
    task automatic toggle(input logic [2:0] mask, input int n);
    begin
        repeat (n)
        begin
            @(posedge sys_clk);
            high_event_pin <= high_event_pin ^ mask[2];
            low_event_pin <= low_event_pin ^ mask[1];
            event_irq_enable_pin <= event_irq_enable_pin ^ mask[0];
        end
    end
    endtask : toggle
endmodule : event_source_model

/* File: testbench/event_counter_input_select_test.sv */
// Bench: APB tasks, pin model and pulse tallies for the event counter block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module event_counter_input_select_test;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr, high_event_pin, low_event_pin, event_irq_enable_pin, e;
    logic        high_count_tick, low_count_tick, low_overflow, irq_event, pwm_clk_tick, counter_pwm_enable;
    logic [31:0] prdata, q, r;
    logic [7:0]  high_event_count, low_event_count, x;
    int          fail_count = 0, checked = 0, n_irq = 0, n_pwm = 0, n_lo = 0, n_hi = 0, n_ov = 0, a, b, c, s, g;
    event_counter_input_select dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .high_event_pin(high_event_pin), .low_event_pin(low_event_pin),
        .event_irq_enable_pin(event_irq_enable_pin), .high_count_tick(high_count_tick),
        .low_count_tick(low_count_tick), .low_overflow(low_overflow), .irq_event(irq_event),
        .pwm_clk_tick(pwm_clk_tick), .counter_pwm_enable(counter_pwm_enable),
        .high_event_count(high_event_count), .low_event_count(low_event_count));
    event_source_model model_u (.sys_clk(sys_clk), .high_event_pin(high_event_pin), .low_event_pin(low_event_pin),
        .event_irq_enable_pin(event_irq_enable_pin));
    always #25 sys_clk = ~sys_clk;
    // Pulse tallies
    always @(posedge sys_clk)
    begin
        n_irq <= n_irq + irq_event;
        n_pwm <= n_pwm + pwm_clk_tick;
        n_lo <= n_lo + low_count_tick;
        n_hi <= n_hi + high_count_tick;
        n_ov <= n_ov + low_overflow;
    end
    // One APB transfer; result in q and e
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    begin
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    end
    endtask : apb
    task check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    begin
        checked++;
        if (got !== ex)
        begin
            $display("mismatch %s expected %h seen %h", nm, ex, got);
            fail_count++;
        end
    end
    endtask : check
    task finish_test;
    begin
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask : finish_test
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        finish_test;
    end
    // Register access, edge modes, pwm gating and clock rates
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        check("clock_control", 32'h0, q);
        check("count_reset", 32'h0, {16'h0, high_event_count, low_event_count});
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, e});
        check("unmapped_data", 32'h0, q);
        apb(1'b1, 8'h08, 32'h0);
        check("count_write_err", 32'h1, {31'h0, e});
        apb(1'b1, 8'h00, 32'h98);
        apb(1'b0, 8'h00, 32'h0);
        check("edge_readback", 32'h98, q);
        $display("test registers done");
        for (c = 0; c < 3; c++)
        begin
            x = {c[1:0], c[1:0], c[1:0], 2'b00};
            apb(1'b1, 8'h00, {24'h0, x});
            apb(1'b0, 8'h08, 32'h0);
            r = q;
            a = n_irq;
            s = low_event_pin;
            model_u.toggle(3'h7, 3);
            repeat (3) @(posedge sys_clk);
            apb(1'b0, 8'h08, 32'h0);
            g = (c == 2) ? 3 : (((c == 1) == (s == 0)) ? 2 : 1);
            check("low_edges", g, {24'h0, q[7:0] - r[7:0]});
            check("high_edges", g, {24'h0, q[15:8] - r[15:8]});
            check("irq_edges", g, n_irq - a);
            check("count_ports", {16'h0, r[15:8] + g[7:0], r[7:0] + g[7:0]}, {16'h0, high_event_count, low_event_count});
        end
        $display("test edges done");
        apb(1'b1, 8'h00, 32'h0a);
        a = n_irq;
        model_u.toggle(3'h1, 2);
        repeat (3) @(posedge sys_clk);
        check("pwm_enable", 32'h1, {31'h0, counter_pwm_enable});
        check("irq_deselected", 32'h0, n_irq - a);
        $display("test pwm gating done");
        for (c = 1; c < 8; c++)
        begin
            s = (c % 3) + 1;
            apb(1'b1, 8'h04, {24'h0, s[1:0], s[1:0], c[2:0], 1'b0});
            repeat (4) @(posedge sys_clk);
            a = n_lo;
            b = n_hi;
            g = n_pwm;
            repeat (128) @(posedge sys_clk);
            check("low_rate", 128 >> s, n_lo - a);
            check("high_rate", 128 >> s, n_hi - b);
            check("pwm_rate", 128 >> (c[2] ? (c[0] ? 6 : 5) : c + 1), n_pwm - g);
        end
        $display("test clock rates done");
        // Low counter at clock/2 wraps once per 512 cycles and clocks the high counter
        apb(1'b1, 8'h04, 32'h12);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        check("cascade_readback", 32'h1, q);
        repeat (4) @(posedge sys_clk);
        a = n_ov;
        b = n_hi;
        repeat (512) @(posedge sys_clk);
        check("low_wraps", 32'h1, n_ov - a);
        check("cascade_rate", 32'h1, n_hi - b);
        $display("test cascade done");
        // Halting the PWM stops its clock and reselects the irq pin
        apb(1'b1, 8'h00, 32'h08);
        repeat (2) @(posedge sys_clk);
        a = n_irq;
        g = n_pwm;
        model_u.toggle(3'h1, 2);
        repeat (3) @(posedge sys_clk);
        check("pwm_halted", 32'h0, {31'h0, counter_pwm_enable});
        check("irq_reselected", 32'h2, n_irq - a);
        check("pwm_ticks_stopped", 32'h0, n_pwm - g);
        $display("test pwm halt done");
        finish_test;
    end
endmodule : event_counter_input_select_test
